// ---- logic/stc_xfer_ctrl0.sv ----
/*
  SCSI transfer control zero: control register, handshake glitch
  filtering, counter clears, channel clear and auto-configuration mode,
  with a classic Wishbone slave for software access.
  Assumes synchronous inputs, one 50 MHz clock and a master that holds
  each request until it sees ack.
*/
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module stc_xfer_ctrl0 #(
  parameter int OFF_W       = 4,
  parameter int TICK_CYCLES = stc_pkg::TICK_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [stc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [stc_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [stc_pkg::DAT_W-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      scsi_req_i,
  input  wire logic                      scsi_ack_i,
  input  wire logic                      xfer_start_i,
  input  wire logic                      sel_timeout_i,
  input  wire logic [7:0]                protocol_bus_i,
  output logic      [7:0]                bus_ctrl_o,
  output logic                           config_bypass_o,
  output logic                           scsi_rst_o,
  output logic                           fifo_clear_o,
  output logic                           req_filtered_o,
  output logic                           ack_filtered_o,
  output logic                           tick_o
);
  import stc_pkg::*;

  localparam logic [OFF_W-1:0] OFF_MAX = {OFF_W{1'b1}};
  localparam logic [OFF_W-1:0] OFF_ONE = OFF_W'(1);

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       rate;
    logic [7:0]       direct;
    logic [23:0]      count;
    logic [31:0]      haddr;
    logic [OFF_W-1:0] offset;
    stc_xfer_state_t  state;
    logic             ack;
    logic [31:0]      rdat;
    logic             req_d;
    logic             ack_d;
    logic [7:0]       bus;
    logic             bypass;
    logic             rst_out;
    logic             fifo_clr;
  } stc_top_t;

  stc_top_t r_reg;
  stc_top_t r_next;

  logic       req_filt;
  logic       ack_filt;
  logic [7:0] tick_count;
  logic [3:0] window;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Rate codes above five stand for transfers faster than 5 MB/s
  function automatic logic rate_is_fast(input logic [7:0] rate);
    return rate[3:0] > RATE_FAST_ABOVE;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Filter window selection
  always_comb begin
    if (!r_reg.ctrl[BIT_FILTER_ON]) begin
      window = FILT_OFF_CYC;
    end else if (rate_is_fast(r_reg.rate)) begin
      window = FILT_FAST_CYC;
    end else if (r_reg.ctrl[BIT_FILTER_EXT]) begin
      window = FILT_EXT_CYC;
    end else begin
      window = FILT_SLOW_CYC;
    end
  end

  stc_filter u_req_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .window_i (window),
    .line_i   (scsi_req_i),
    .line_o   (req_filt)
  );

  stc_filter u_ack_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .window_i (window),
    .line_i   (scsi_ack_i),
    .line_o   (ack_filt)
  );

  stc_tick_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .en_i    (r_reg.ctrl[BIT_AUTO_CFG]),
    .tick_o  (tick_o),
    .count_o (tick_count)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic        hit;
    logic        wr;
    logic [7:0]  idx;
    logic        req_rise;
    logic        ack_rise;
    logic        clr_counts;
    logic        chan_clr;
    logic [31:0] merged;
    logic        auto_cfg;

    r_next     = r_reg;
    hit        = wb_cyc_i & wb_stb_i;
    idx        = wb_adr_i[ADR_W-1:2];
    // Writes land on the edge where the master sees ack
    wr         = hit & wb_we_i & r_reg.ack;
    req_rise   = req_filt & ~r_reg.req_d;
    ack_rise   = ack_filt & ~r_reg.ack_d;
    clr_counts = 1'b0;
    chan_clr   = 1'b0;
    merged     = 32'h0000_0000;
    auto_cfg   = r_reg.ctrl[BIT_AUTO_CFG];

    r_next.req_d    = req_filt;
    r_next.ack_d    = ack_filt;
    r_next.fifo_clr = 1'b0;

    // Bus answer: one wait state, ack dropped the cycle after
    r_next.ack = hit & ~r_reg.ack;
    if (hit & ~r_reg.ack) begin
      case (idx)
        IDX_XFER_CTRL0: r_next.rdat = {24'h000000, r_reg.ctrl};
        IDX_RATE:       r_next.rdat = {24'h000000, r_reg.rate};
        IDX_DIRECT:     r_next.rdat = {24'h000000, r_reg.direct};
        IDX_COUNT:      r_next.rdat = {8'h00, r_reg.count};
        IDX_HADDR:      r_next.rdat = r_reg.haddr;
        IDX_STATUS:     r_next.rdat = 32'({r_reg.state, r_reg.offset});
        IDX_TIMER:      r_next.rdat = {24'h000000, tick_count};
        default:        r_next.rdat = 32'h0000_0000;
      endcase
    end

    // Transfer control state machine and its counters
    case (r_reg.state)
      ST_IDLE: begin
        if (xfer_start_i && (r_reg.count != 24'h000000)) begin
          r_next.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (req_rise && !ack_rise && (r_reg.offset != OFF_MAX)) begin
          r_next.offset = r_reg.offset + OFF_ONE;
        end else if (ack_rise && !req_rise &&
                     (r_reg.offset != '0)) begin
          r_next.offset = r_reg.offset - OFF_ONE;
        end
        if (ack_rise) begin
          r_next.haddr = r_reg.haddr + 32'h0000_0001;
          r_next.count = r_reg.count - 24'h000001;
          if (r_reg.count == 24'h000001) begin
            r_next.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (xfer_start_i && (r_reg.count != 24'h000000)) begin
          r_next.state = ST_ACTIVE;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // Register writes override counter activity in the same cycle
    if (wr) begin
      case (idx)
        IDX_XFER_CTRL0: begin
          merged      = wb_merge({24'h000000, r_reg.ctrl}, wb_dat_i,
                                 wb_sel_i);
          // Only bits 7, 6 and 2 are stored; the rest read zero
          r_next.ctrl = merged[7:0] & CTRL0_KEEP;
          clr_counts  = wb_sel_i[0] & wb_dat_i[BIT_CLR_COUNTS];
          chan_clr    = wb_sel_i[0] & wb_dat_i[BIT_CHAN_CLR];
        end
        IDX_RATE: begin
          merged      = wb_merge({24'h000000, r_reg.rate}, wb_dat_i,
                                 wb_sel_i);
          r_next.rate = merged[7:0];
        end
        IDX_DIRECT: begin
          merged        = wb_merge({24'h000000, r_reg.direct}, wb_dat_i,
                                   wb_sel_i);
          r_next.direct = merged[7:0];
        end
        IDX_COUNT: begin
          merged       = wb_merge({8'h00, r_reg.count}, wb_dat_i,
                                  wb_sel_i);
          r_next.count = merged[23:0];
        end
        IDX_HADDR: begin
          r_next.haddr = wb_merge(r_reg.haddr, wb_dat_i, wb_sel_i);
        end
        default: begin
          merged = 32'h0000_0000;
        end
      endcase
    end

    // Action bits are never stored, so they always read back zero
    if (clr_counts) begin
      r_next.count = 24'h000000;
      r_next.haddr = 32'h0000_0000;
    end
    if (chan_clr) begin
      // Counters untouched here on purpose: a channel clear may come
      // between chained transfers that share the same counts
      r_next.offset   = '0;
      r_next.fifo_clr = 1'b1;
      r_next.state    = ST_IDLE;
    end

    // Bus signal steering and reset suppression
    if (auto_cfg) begin
      r_next.bus = r_reg.direct;
    end else begin
      r_next.bus = protocol_bus_i;
    end
    r_next.bypass  = auto_cfg;
    r_next.rst_out = sel_timeout_i & ~auto_cfg;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg        <= '0;
      r_reg.ctrl   <= CTRL0_RST;
      r_reg.rate   <= RATE_RST;
      r_reg.direct <= DIRECT_RST;
      r_reg.state  <= ST_IDLE;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_dat_o        = r_reg.rdat;
  assign wb_ack_o        = r_reg.ack;
  assign bus_ctrl_o      = r_reg.bus;
  assign config_bypass_o = r_reg.bypass;
  assign scsi_rst_o      = r_reg.rst_out;
  assign fifo_clear_o    = r_reg.fifo_clr;
  assign req_filtered_o  = req_filt;
  assign ack_filtered_o  = ack_filt;
endmodule

// ---- logic/stc_pkg.sv ----
/*
  Shared constants and types for the SCSI transfer control zero block:
  register indices, field positions, reset values, filter timing, tick
  timing and the transfer state encoding.
  Assumes a single 50 MHz clock and a 32-bit classic Wishbone bus.
*/
package stc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Bus and register map (byte address is four times the index)
  localparam int         ADR_W          = 10;
  localparam int         DAT_W          = 32;
  localparam logic [7:0] IDX_XFER_CTRL0 = 8'h01;
  localparam logic [7:0] IDX_RATE       = 8'h02;
  localparam logic [7:0] IDX_DIRECT     = 8'h03;
  localparam logic [7:0] IDX_COUNT      = 8'h04;
  localparam logic [7:0] IDX_HADDR      = 8'h05;
  localparam logic [7:0] IDX_STATUS     = 8'h06;
  localparam logic [7:0] IDX_TIMER      = 8'h07;

  //////////////////////////////////////////////////////////////////////////
  // Fields of scsi_transfer_control_0
  localparam int         BIT_FILTER_ON  = 7;
  localparam int         BIT_FILTER_EXT = 6;
  localparam int         BIT_CLR_COUNTS = 4;
  localparam int         BIT_AUTO_CFG   = 2;
  localparam int         BIT_CHAN_CLR   = 1;
  localparam logic [7:0] CTRL0_KEEP     = 8'hc4;
  localparam logic [7:0] CTRL0_RST      = 8'h00;
  localparam logic [7:0] RATE_RST       = 8'h00;
  localparam logic [7:0] DIRECT_RST     = 8'h00;
  localparam logic [3:0] RATE_FAST_ABOVE = 4'h5;

  //////////////////////////////////////////////////////////////////////////
  // Timing, all in picoseconds
  localparam int CLK_PS            = 20000;
  localparam int FILT_FAST_MIN_PS  = 12500;
  localparam int FILT_FAST_MAX_PS  = 25000;
  localparam int FILT_SLOW_MIN_PS  = 50000;
  localparam int FILT_SLOW_MAX_PS  = 62500;
  localparam int FILT_EXT_MIN_PS   = 62600;
  localparam int FILT_EXT_MAX_PS   = 75000;
  localparam int TICK_PS           = 1000000;

  function automatic int ceil_cyc(input int t_ps);
    int c;
    c = (t_ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Each window uses the rounded-up lower bound so short glitches never pass
  localparam logic [3:0] FILT_FAST_CYC = 4'(ceil_cyc(FILT_FAST_MIN_PS));
  localparam logic [3:0] FILT_SLOW_CYC = 4'(ceil_cyc(FILT_SLOW_MIN_PS));
  localparam logic [3:0] FILT_EXT_CYC  = 4'(ceil_cyc(FILT_EXT_MIN_PS));
  localparam logic [3:0] FILT_OFF_CYC  = 4'h0;
  localparam int         TICK_CYC      = ceil_cyc(TICK_PS);

  //////////////////////////////////////////////////////////////////////////
  // Transfer control states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_DONE   = 3'b100
  } stc_xfer_state_t;

endpackage

// ---- logic/stc_filter.sv ----
/*
  Digital glitch filter for one incoming handshake line.
  Assumes the input is already synchronous to clk_i; a window of zero
  passes the input through one register stage.
*/
`timescale 1ns/100ps
module stc_filter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [3:0] window_i,
  input  wire logic       line_i,
  output logic            line_o
);
  import stc_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       out;
  } stc_filt_t;

  stc_filt_t r_reg;
  stc_filt_t r_next;

  always_comb begin
    r_next = r_reg;
    if (window_i == FILT_OFF_CYC) begin
      r_next.out = line_i;
      r_next.cnt = 4'h0;
    end else if (line_i == r_reg.out) begin
      r_next.cnt = 4'h0;
    end else if (r_reg.cnt + 4'h1 >= window_i) begin
      // Change accepted only after a full window of stable level
      r_next.out = line_i;
      r_next.cnt = 4'h0;
    end else begin
      r_next.cnt = r_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign line_o = r_reg.out;
endmodule

// ---- logic/stc_tick_timer.sv ----
/*
  Protocol tick timer: a prescaler that emits a tick pulse and counts
  ticks while enabled, and is held at zero while disabled.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module stc_tick_timer #(
  parameter int TICK_CYCLES = stc_pkg::TICK_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       en_i,
  output logic            tick_o,
  output logic [7:0]      count_o
);
  import stc_pkg::*;

  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic          tick;
    logic [7:0]    count;
  } stc_tick_t;

  stc_tick_t r_reg;
  stc_tick_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (!en_i) begin
      r_next.pre   = '0;
      r_next.count = 8'h00;
    end else if (r_reg.pre == PRE_LAST) begin
      r_next.pre   = '0;
      r_next.tick  = 1'b1;
      r_next.count = r_reg.count + 8'h01;
    end else begin
      r_next.pre = r_reg.pre + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign tick_o  = r_reg.tick;
  assign count_o = r_reg.count;
endmodule

// ---- sim/stc_xfer_ctrl0_assertions.sv ----
/*
  Port checker for the transfer control zero block.
  Assumes ce_i stays high and a master that holds requests until ack.
*/
`timescale 1ns/100ps
module stc_xfer_ctrl0_chk
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             scsi_req_i,
  input wire logic             scsi_ack_i,
  input wire logic             sel_timeout_i,
  input wire logic [7:0]       protocol_bus_i,
  input wire logic [7:0]       bus_ctrl_o,
  input wire logic             config_bypass_o,
  input wire logic             scsi_rst_o,
  input wire logic             fifo_clear_o,
  input wire logic             req_filtered_o,
  input wire logic             ack_filtered_o,
  input wire logic             tick_o
);
  localparam int TWAIT = TICK_CYCLES + 2;
  logic ctl_wr;
  logic fon_q;
  logic ac_q;
  assign ctl_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
                  && wb_sel_i[0] && wb_adr_i[9:2] == IDX_XFER_CTRL0;
  // Mode mirrors load at the edge where the write lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fon_q <= 1'b0;
      ac_q  <= 1'b0;
    end else if (ctl_wr) begin
      fon_q <= wb_dat_i[BIT_FILTER_ON];
      ac_q  <= wb_dat_i[BIT_AUTO_CFG];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence chan_clr_wr;
    ctl_wr && wb_dat_i[BIT_CHAN_CLR];
  endsequence
  // Two quiet cycles so registered outputs have caught up with the mode
  sequence mode_off;
    !$past(rst_i) && !ac_q && !$past(ac_q);
  endsequence
  a_ack_wait: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=>
    wb_ack_o) else $error("ack late");
  a_ctl_read: assert property (
    (wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i[9:2] == IDX_XFER_CTRL0)
    |-> (wb_dat_o & ~{24'h0, CTRL0_KEEP}) == 32'h0) else $error("ctl bits");
  a_clr_cause: assert property (chan_clr_wr |=> fifo_clear_o)
    else $error("fifo clear missing");
  a_clr_pulse: assert property (fifo_clear_o |->
    $past(ctl_wr) && $past(wb_dat_i[BIT_CHAN_CLR]) ##1 !fifo_clear_o)
    else $error("fifo clear stray");
  a_mode_follow: assert property (ctl_wr |->
    ##[1:2] config_bypass_o == ac_q) else $error("bypass wrong");
  a_normal_path: assert property (mode_off |->
    bus_ctrl_o == $past(protocol_bus_i)) else $error("bus path wrong");
  a_rst_gate: assert property (!$past(rst_i) |->
    scsi_rst_o == ($past(sel_timeout_i) && !$past(ac_q)))
    else $error("scsi reset wrong");
  a_tick_gap: assert property (tick_o |=> !tick_o [*3])
    else $error("tick too soon");
  a_tick_off: assert property (mode_off ##1 !ac_q |-> !tick_o)
    else $error("tick while off");
  a_tick_run: assert property (
    ac_q |-> ##[0:TWAIT] (tick_o || !ac_q)) else $error("tick missing");
  a_filt_off: assert property (
    (!$past(rst_i) && !fon_q && !$past(fon_q) && !$past(fon_q, 2)) |->
    req_filtered_o == $past(scsi_req_i) &&
    ack_filtered_o == $past(scsi_ack_i)) else $error("filter not bypassed");
endmodule

// ---- sim/stc_scsi_peer.sv ----
/*
  Peripheral on the far side of the incoming handshake lines.
  Assumes one caller at a time; lines idle low between pulses.
*/
`timescale 1ns/100ps
module stc_scsi_peer (
  input  wire logic clk_i,
  output logic      scsi_req_o,
  output logic      scsi_ack_o
);
  initial begin
    scsi_req_o = 1'b0;
    scsi_ack_o = 1'b0;
  end
  // Waits for an edge first, so two calls never collide in one step
  task automatic drive(input logic r, input logic a);
    @(posedge clk_i);
    scsi_req_o <= r;
    scsi_ack_o <= a;
  endtask
endmodule

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for stc_xfer_ctrl0 with a peripheral model.
  Assumes the checker and peripheral files are compiled before it.
*/
`timescale 1ns/100ps
module tb_top;
  import stc_pkg::*;
  localparam int TICKS = 4;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, v, d, pb, cnt, had;
  logic        scsi_req_i, scsi_ack_i, xfer_start_i, sel_timeout_i;
  logic [7:0]  protocol_bus_i, bus_ctrl_o;
  logic        config_bypass_o, scsi_rst_o, fifo_clear_o, last_clr;
  logic        req_filtered_o, ack_filtered_o, tick_o;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n, t, tr, ta;

  stc_xfer_ctrl0 #(.TICK_CYCLES(TICKS)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scsi_req_i(scsi_req_i), .scsi_ack_i(scsi_ack_i),
    .xfer_start_i(xfer_start_i), .sel_timeout_i(sel_timeout_i),
    .protocol_bus_i(protocol_bus_i), .bus_ctrl_o(bus_ctrl_o),
    .config_bypass_o(config_bypass_o), .scsi_rst_o(scsi_rst_o),
    .fifo_clear_o(fifo_clear_o), .req_filtered_o(req_filtered_o),
    .ack_filtered_o(ack_filtered_o), .tick_o(tick_o));
  stc_scsi_peer peer (.clk_i(clk_i), .scsi_req_o(scsi_req_i),
    .scsi_ack_o(scsi_ack_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One classic cycle; the idle edge after it also samples fifo_clear_o
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [31:0] wd);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 50) begin
      miscompares++;
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
    last_clr = fifo_clear_o;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 32'h0);
    chk($sformatf("reg_%0h", idx), q, e);
  endtask
  task automatic pls(input logic r, input logic a);
    peer.drive(r, a);
    repeat (3) @(posedge clk_i);
    peer.drive(1'b0, 1'b0);
    repeat (3) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, xfer_start_i} = 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i, sel_timeout_i, protocol_bus_i} = '0;
    v = $urandom(57);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 1; i <= 8; i++)
      rd((i == 8) ? 8'h3c : 8'(i), (i == 6) ? 32'h10 : 32'h0);
    for (int i = 0; i < 4; i++) begin
      cnt = $urandom & 32'hffffff;
      had = $urandom;
      wb(1'b1, IDX_COUNT, cnt);
      wb(1'b1, IDX_HADDR, had);
      v = (i == 0) ? 32'hff : ($urandom & 32'hff);
      wb(1'b1, IDX_XFER_CTRL0, v);
      chk("chan_clr", last_clr, v[1]);
      rd(IDX_XFER_CTRL0, v & {24'h0, CTRL0_KEEP});
      if (v[BIT_CLR_COUNTS])
        {cnt, had} = '0;
      rd(IDX_COUNT, cnt);
      rd(IDX_HADDR, had);
    end
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'h0 : (i < 3) ? 32'h80 : 32'hc0;
      d = (i == 1 || i == 4) ? 32'h6 : 32'h5;
      wb(1'b1, IDX_RATE, d);
      wb(1'b1, IDX_XFER_CTRL0, v);
      // Lines change after an edge; the filter register follows at the
      // edge where the window is used up, one edge when filtering is off
      n = !v[7] ? 1 : (d[3:0] > RATE_FAST_ABOVE) ? FILT_FAST_CYC :
          v[6] ? FILT_EXT_CYC : FILT_SLOW_CYC;
      peer.drive(1'b1, 1'b1);
      {tr, ta} = '0;
      for (int k = 1; k < 20; k++) begin
        @(posedge clk_i);
        #1;
        if (tr == 0 && req_filtered_o === 1'b1) tr = k;
        if (ta == 0 && ack_filtered_o === 1'b1) ta = k;
      end
      chk("req_delay", tr, n);
      chk("ack_delay", ta, n);
      peer.drive(1'b0, 1'b0);
      repeat (8) @(posedge clk_i);
    end
    wb(1'b1, IDX_XFER_CTRL0, 32'h0);
    cnt = 32'h2;
    had = $urandom;
    wb(1'b1, IDX_COUNT, cnt);
    wb(1'b1, IDX_HADDR, had);
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, IDX_XFER_CTRL0, 32'h2);
      chk("chan_clr", last_clr, 1'b1);
      rd(IDX_STATUS, 32'h10);
      rd(IDX_COUNT, cnt);
      rd(IDX_HADDR, had);
      @(posedge clk_i);
      xfer_start_i <= 1'b1;
      @(posedge clk_i);
      xfer_start_i <= 1'b0;
      pls(1'b1, 1'b0);
      pls(1'b1, 1'b0);
      pls(1'b0, 1'b1);
      cnt = cnt - 1;
      had = had + 1;
      rd(IDX_STATUS, ((cnt == 0) ? 32'h40 : 32'h20) | 32'h1);
    end
    wb(1'b1, IDX_COUNT, 32'h9);
    wb(1'b1, IDX_XFER_CTRL0, 32'h10);
    rd(IDX_COUNT, 32'h0);
    rd(IDX_HADDR, 32'h0);
    d = $urandom & 32'hff;
    pb = $urandom & 32'hff;
    protocol_bus_i <= pb[7:0];
    wb(1'b1, IDX_DIRECT, d);
    rd(IDX_DIRECT, d);
    for (int m = 1; m >= 0; m--) begin
      wb(1'b1, IDX_XFER_CTRL0, m ? 32'h4 : 32'h0);
      repeat (3) @(posedge clk_i);
      chk("bypass", config_bypass_o, m);
      chk("bus_ctrl", bus_ctrl_o, m ? d : pb);
      sel_timeout_i <= 1'b1;
      @(posedge clk_i);
      sel_timeout_i <= 1'b0;
      @(posedge clk_i);
      chk("scsi_rst", scsi_rst_o, !m);
      t = 0;
      repeat (16) begin
        @(posedge clk_i);
        if (tick_o === 1'b1) t++;
      end
      chk("ticks", t, m ? 16 / TICKS : 0);
    end
    rd(IDX_TIMER, 32'h0);
    close_out();
  end
endmodule

bind stc_xfer_ctrl0 stc_xfer_ctrl0_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .scsi_req_i(scsi_req_i), .scsi_ack_i(scsi_ack_i),
  .sel_timeout_i(sel_timeout_i), .protocol_bus_i(protocol_bus_i),
  .bus_ctrl_o(bus_ctrl_o), .config_bypass_o(config_bypass_o),
  .scsi_rst_o(scsi_rst_o), .fifo_clear_o(fifo_clear_o),
  .req_filtered_o(req_filtered_o), .ack_filtered_o(ack_filtered_o),
  .tick_o(tick_o));
